//--- rail_residual_consts.svh
// Offsets, field positions, reset values and timing counts of the
// rail residual-voltage flag block.
// Assumes one 25 MHz core clock and an AXI4-Lite register bus.
`ifndef RAIL_RESIDUAL_CONSTS_SVH
`define RAIL_RESIDUAL_CONSTS_SVH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define FLAGS_INDEX 8'h31
`define IRQ_MASK_INDEX 8'h32
`define IRQ_STATUS_INDEX 8'h33
`define FLAGS_ADDR 8'(4 * `FLAGS_INDEX)
`define IRQ_MASK_ADDR 8'(4 * `IRQ_MASK_INDEX)
`define IRQ_STATUS_ADDR 8'(4 * `IRQ_STATUS_INDEX)

// ****************************************
// Field positions
// ****************************************
`define BUCK_A_BIT 0
`define BUCK_B_BIT 1
`define BUCK_C_BIT 2
`define LDO_A_BIT 3
`define LDO_B_BIT 5

// ****************************************
// Reset values
// ****************************************
`define FLAGS_RESET 8'h00
`define IRQ_MASK_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 40
`define DISCHARGE_SAMPLE_US 4000
`define DISCHARGE_SAMPLE_CYCLES ((`DISCHARGE_SAMPLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************
// Bus responses
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rail_residual_pkg.sv
// Types of the rail residual-voltage flag block.
// Assumes nothing beyond the constants header.
package rail_residual_pkg;

  // ****************************************
  // One bit per monitored rail
  // ****************************************
  typedef struct packed {
    logic ldo_b;
    logic ldo_a;
    logic buck_c;
    logic buck_b;
    logic buck_a;
  } rail_set_t;

  // ****************************************
  // Register select and check sequence
  // ****************************************
  typedef enum logic [1:0] {SEL_FLAGS, SEL_MASK, SEL_STATUS, SEL_NONE} reg_sel_t;

  typedef enum logic [1:0] {CHECK_IDLE, CHECK_WAIT, CHECK_SAMPLE} check_state_t;

  // ****************************************
  // Bus response pair
  // ****************************************
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } bus_answer_t;

endpackage : rail_residual_pkg

//--- rail_residual_flags.sv
// Sticky residual-voltage flags for three buck and two LDO rails,
// with discharge-check sampling, AXI4-Lite access and an interrupt.
// Assumes detectors and sequencer drive inputs synchronous to aclk.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "rail_residual_consts.svh"

module rail_residual_flags
  import rail_residual_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = `DISCHARGE_SAMPLE_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rail_set_t residual_voltage,
  input wire rail_set_t rail_turn_on,
  input wire logic discharge_check_start,
  output logic discharge_check_busy,
  output logic discharge_check_done,
  output logic irq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic reg_sel_t decode(input logic [7:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == `FLAGS_ADDR)
    begin
      sel = SEL_FLAGS;
    end
    else if (addr == `IRQ_MASK_ADDR)
    begin
      sel = SEL_MASK;
    end
    else if (addr == `IRQ_STATUS_ADDR)
    begin
      sel = SEL_STATUS;
    end
    return sel;
  endfunction : decode

  // Places rail bits at their register positions, reserved bits zero
  function automatic logic [7:0] to_reg(input rail_set_t r);
    logic [7:0] v;
    v = 8'h00;
    v[`BUCK_A_BIT] = r.buck_a;
    v[`BUCK_B_BIT] = r.buck_b;
    v[`BUCK_C_BIT] = r.buck_c;
    v[`LDO_A_BIT] = r.ldo_a;
    v[`LDO_B_BIT] = r.ldo_b;
    return v;
  endfunction : to_reg

  function automatic rail_set_t from_reg(input logic [7:0] v);
    rail_set_t r;
    r.buck_a = v[`BUCK_A_BIT];
    r.buck_b = v[`BUCK_B_BIT];
    r.buck_c = v[`BUCK_C_BIT];
    r.ldo_a = v[`LDO_A_BIT];
    r.ldo_b = v[`LDO_B_BIT];
    return r;
  endfunction : from_reg

  // ****************************************
  // Storage
  // ****************************************
  rail_set_t flags;
  rail_set_t irq_mask;
  rail_set_t irq_status;
  rail_set_t sampled_hits;
  rail_set_t events;
  check_state_t check_state;
  logic [31:0] check_count;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  reg_sel_t write_sel;
  reg_sel_t read_sel;
  rail_set_t write_clear;
  rail_set_t mask_value;
  logic status_read;
  bus_answer_t next_answer;

  // ****************************************
  // Discharge check sequence
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      check_state <= CHECK_IDLE;
      check_count <= 32'h0000_0000;
    end
    else
    begin
      unique case (check_state)
        CHECK_IDLE:
        begin
          check_count <= 32'h0000_0000;
          if (discharge_check_start)
          begin
            check_state <= CHECK_WAIT;
          end
        end
        CHECK_WAIT:
        begin
          check_count <= check_count + 32'h0000_0001;
          if (check_count == 32'(SAMPLE_CYCLES - 1))
          begin
            check_state <= CHECK_SAMPLE;
          end
        end
        CHECK_SAMPLE:
        begin
          check_state <= CHECK_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      discharge_check_busy <= 1'b0;
      discharge_check_done <= 1'b0;
    end
    else
    begin
      discharge_check_busy <= (check_state != CHECK_IDLE) || discharge_check_start;
      discharge_check_done <= (check_state == CHECK_SAMPLE);
    end
  end
  // Residual rails at the sample instant
  always_comb
  begin
    sampled_hits = (check_state == CHECK_SAMPLE) ? residual_voltage : '0;
    events = sampled_hits | (residual_voltage & rail_turn_on);
  end

  // ****************************************
  // Write channel
  // ****************************************
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign write_sel = decode(aw_addr);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
      begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
      begin
        w_held <= 1'b0;
      end
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (write_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // Ones written to the flag register, only on the low byte lane
  always_comb
  begin
    write_clear = '0;
    mask_value = irq_mask;
    if (do_write && w_strb[0])
    begin
      if (write_sel == SEL_FLAGS)
      begin
        write_clear = from_reg(w_data[7:0]);
      end
      if (write_sel == SEL_MASK)
      begin
        mask_value = from_reg(w_data[7:0]);
      end
    end
  end

  // ****************************************
  // Residual flags
  // ****************************************
  // Set wins over a same-cycle clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags <= from_reg(`FLAGS_RESET);
    end
    else
    begin
      flags.buck_a <= events.buck_a | (flags.buck_a & ~write_clear.buck_a);
      flags.buck_b <= events.buck_b | (flags.buck_b & ~write_clear.buck_b);
      flags.buck_c <= events.buck_c | (flags.buck_c & ~write_clear.buck_c);
      flags.ldo_a <= events.ldo_a | (flags.ldo_a & ~write_clear.ldo_a);
      flags.ldo_b <= events.ldo_b | (flags.ldo_b & ~write_clear.ldo_b);
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  assign status_read = do_read && (read_sel == SEL_STATUS);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_mask <= from_reg(`IRQ_MASK_RESET);
      irq_status <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_mask <= mask_value;
      irq_status <= events | (status_read ? rail_set_t'('0) : irq_status);
      irq <= |(irq_status & irq_mask);
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign read_sel = decode(s_axi_araddr);
  always_comb
  begin
    next_answer.data = 32'h0000_0000;
    next_answer.resp = `RESP_OKAY;
    unique case (read_sel)
      SEL_FLAGS: next_answer.data = {24'h000000, to_reg(flags)};
      SEL_MASK: next_answer.data = {24'h000000, to_reg(irq_mask)};
      SEL_STATUS: next_answer.data = {24'h000000, to_reg(irq_status)};
      SEL_NONE: next_answer.resp = `RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      if (do_read)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_answer.data;
        s_axi_rresp <= next_answer.resp;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      else if (!s_axi_rvalid)
      begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : rail_residual_flags

//--- rail_residual_checker.sv
// Concurrent checks on the rail residual flag block.
// Assumes binding to the ports of its top module.
`timescale 1ns/100ps
module rail_residual_checker
#(
  parameter int unsigned SAMPLE_CYCLES = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic discharge_check_start,
  input wire logic discharge_check_busy,
  input wire logic discharge_check_done
);
  localparam int LO = SAMPLE_CYCLES;
  localparam int HI = SAMPLE_CYCLES + 4;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ****************
  // Bus and check timing
  // ****************
  a_rsv_read_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0 && !s_axi_rdata[4])
    else $error("reserved bits read nonzero");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during answer");
  a_write_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  a_write_end: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("response not released");
  a_check_wait: assert property (
    discharge_check_start && !discharge_check_busy
      |=> (discharge_check_busy && !discharge_check_done)[*8])
    else $error("check ended early");
  a_check_done: assert property (
    discharge_check_start && !discharge_check_busy |-> ##[LO:HI] discharge_check_done)
    else $error("check never done");
  a_done_pulse: assert property (
    discharge_check_done |=> !discharge_check_done && !discharge_check_busy)
    else $error("done not one pulse");
endmodule : rail_residual_checker

//--- rail_residual_flags_tb.sv
// Self-checking bench of the rail residual flag block.
// Assumes the block's header constants and package.
`timescale 1ns/100ps
`include "rail_residual_consts.svh"
module rail_residual_flags_tb
  import rail_residual_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic arv = 1'b0;
  logic start = 1'b0;
  rail_set_t rv = 5'h00;
  rail_set_t on = 5'h00;
  wire logic awr, wr, bv, arr, rvl, busy, done, irq;
  wire logic [1:0] br, rr;
  wire logic [31:0] rd;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int mf = 0;
  int mm = 0;
  int ms = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic [3:0] s;
  logic [4:0] x, y;
  logic [7:0] adr [3] = '{`FLAGS_ADDR, `IRQ_MASK_ADDR, `IRQ_STATUS_ADDR};

  always #20 aclk = ~aclk;

  rail_residual_flags #(.SAMPLE_CYCLES(8)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rvl), .s_axi_rready(1'b1), .residual_voltage(rv),
    .rail_turn_on(on), .discharge_check_start(start), .discharge_check_busy(busy),
    .discharge_check_done(done), .irq(irq));

  // ****************
  // Tasks
  // ****************
  function logic [31:0] widen(input logic [4:0] v);
    return {26'h0, v[4], 1'b0, v[3:0]};
  endfunction : widen

  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task wrt(input logic [7:0] a, input logic [31:0] v, input logic [3:0] t);
    awa <= a;
    wd <= v;
    ws <= t;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end
    while (!bv);
    r = br;
  endtask : wrt

  task rdr(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end
    while (!rvl);
    d = rd;
    r = rr;
  endtask : rdr

  task wrap_up;
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      error_cnt++;
      wrap_up;
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    void'($urandom(7294));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 3; i++)
    begin
      rdr(adr[i]);
      chk("reset value", d, 32'h0);
    end
    rdr(8'h00);
    chk("unmapped rresp", 32'(r), 32'(`RESP_SLVERR));
    chk("unmapped rdata", d, 32'h0);
    wrt(8'h00, 32'hff, 4'hf);
    chk("unmapped bresp", 32'(r), 32'(`RESP_SLVERR));
    repeat (24)
    begin
      x = 5'($urandom);
      y = 5'($urandom);
      rv <= x;
      on <= y;
      @(posedge aclk);
      on <= 5'h00;
      mf |= widen(x & y);
      ms |= widen(x & y);
      rv <= ~x;
      start <= 1'b1;
      @(posedge aclk);
      start <= 1'b0;
      repeat (3) @(posedge aclk);
      x = 5'($urandom);
      rv <= x;
      do @(posedge aclk);
      while (!done);
      mf |= widen(x);
      ms |= widen(x);
      y = 5'($urandom);
      wrt(`IRQ_MASK_ADDR, widen(y) | ($urandom & 32'hffff_ffd0), 4'hf);
      mm = widen(y);
      repeat (2) @(posedge aclk);
      chk("irq", 32'(irq), 32'((ms & mm) != 0));
      rdr(`IRQ_MASK_ADDR);
      chk("mask", d, mm);
      rdr(`FLAGS_ADDR);
      chk("flags set", d, mf);
      d = $urandom;
      s = 4'($urandom);
      wrt(`FLAGS_ADDR, d, s);
      if (s[0]) mf &= ~(d & 32'h2f);
      chk("bresp", 32'(r), 32'(`RESP_OKAY));
      rdr(`FLAGS_ADDR);
      chk("flags cleared", d, mf);
      rdr(`IRQ_STATUS_ADDR);
      chk("status", d, ms);
      ms = 0;
      repeat (2) @(posedge aclk);
      chk("irq clear", 32'(irq), 32'h0);
    end
    wrap_up;
  end
endmodule : rail_residual_flags_tb

bind rail_residual_flags rail_residual_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk_u (
  .aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .discharge_check_start,
  .discharge_check_busy, .discharge_check_done);
